// ===== csr_map.vh
// register offsets, field positions and reset values for the service request logic
`ifndef CSR_MAP_VH
`define CSR_MAP_VH
`define CSR_OFF_ENABLES 8'h06
`define CSR_OFF_CHAN_SEL 8'h40
`define CSR_OFF_SUMMARY 8'h41
`define CSR_OFF_RX_STATUS 8'h42
`define CSR_OFF_VECTOR 8'h43
`define CSR_OFF_IRQ_STAT 8'h44
`define CSR_OFF_IRQ_MASK 8'h45
`define CSR_OFF_ACK 8'h46
`define CSR_OFF_PENDING 8'h47
`define CSR_EN_MODEM 7
`define CSR_EN_RECEIVE_DATA_ENABLE 4
`define CSR_EN_TXFIFO 2
`define CSR_EN_TXSHIFT 1
`define CSR_EN_NO_NEW_DATA_TIMEOUT_ENABLE 0
`define CSR_EN_WMASK 8'h97
`define CSR_EN_RESET 8'h00
`define CSR_PEND_RX 0
`define CSR_PEND_TX 1
`define CSR_PEND_MDM 2
`define CSR_PEND_EXC 3
`define CSR_IT_NONE 3'h0
`define CSR_IT_MODEM 3'h1
`define CSR_IT_TX 3'h2
`define CSR_IT_RX 3'h3
`define CSR_IT_RX_EXC 3'h7
`define CSR_RDS_TIMEOUT 7
`define CSR_IRQ_RESET 4'h0
`define CSR_CHAN_RESET 2'h0
`endif

// ===== csr_chan.v
// one channel: enable register, condition edges and pending request flags
`timescale 1ns/100ps
`include "csr_map.vh"
module csr_chan (
	input wire i_ref_clk,
	input wire i_arst_n,
	input wire i_en_we,
	input wire [7:0] i_en_wdata,
	input wire [3:0] i_ack,
	input wire i_modem_change,
	input wire i_rx_has_chars,
	input wire i_rx_thresh_hit,
	input wire i_rx_timeout_hit,
	input wire i_tx_fifo_empty,
	input wire i_tx_hold_full,
	input wire i_tx_shift_busy,
	input wire i_tx_shift_empty,
	input wire i_rx_fifo_empty,
	input wire i_rx_idle_expired,
	output wire [7:0] o_enables,
	output wire [3:0] o_pend,
	output wire [3:0] o_evt
);
	reg [7:0] en_q;
	reg [3:0] pend_q;
	reg [3:0] pend_d;
	reg tx_fifo_empty_q;
	reg tx_shift_empty_q;
	reg no_new_data_timeout_enable_cond_q;
	wire no_new_data_timeout_enable_cond;
	wire tx_fifo_rise;
	wire tx_shift_rise;
	wire [3:0] set;

	assign no_new_data_timeout_enable_cond = i_rx_fifo_empty & i_rx_idle_expired;
	// fifo-empty request only while holding and shift registers still carry data
	assign tx_fifo_rise = i_tx_fifo_empty & ~tx_fifo_empty_q & i_tx_hold_full & i_tx_shift_busy;
	assign tx_shift_rise = i_tx_shift_empty & ~tx_shift_empty_q;

	assign set[`CSR_PEND_MDM] = en_q[`CSR_EN_MODEM] & i_modem_change;
	assign set[`CSR_PEND_RX] = en_q[`CSR_EN_RECEIVE_DATA_ENABLE] & i_rx_has_chars
		& (i_rx_thresh_hit | i_rx_timeout_hit);
	assign set[`CSR_PEND_TX] = (en_q[`CSR_EN_TXFIFO] & tx_fifo_rise)
		| (en_q[`CSR_EN_TXSHIFT] & tx_shift_rise);
	assign set[`CSR_PEND_EXC] = en_q[`CSR_EN_NO_NEW_DATA_TIMEOUT_ENABLE] & no_new_data_timeout_enable_cond & ~no_new_data_timeout_enable_cond_q;

	assign o_enables = en_q;
	assign o_pend = pend_q;
	assign o_evt = set;

	always @*
	begin
		// a new condition wins over a host acknowledge in the same cycle
		pend_d = (pend_q & ~i_ack) | set;
	end

	always @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			en_q <= `CSR_EN_RESET;
			pend_q <= 4'h0;
			tx_fifo_empty_q <= 1'b0;
			tx_shift_empty_q <= 1'b0;
			no_new_data_timeout_enable_cond_q <= 1'b0;
		end
		else
		begin
			if (i_en_we)
			begin
				en_q <= i_en_wdata & `CSR_EN_WMASK;
			end
			pend_q <= pend_d;
			tx_fifo_empty_q <= i_tx_fifo_empty;
			tx_shift_empty_q <= i_tx_shift_empty;
			no_new_data_timeout_enable_cond_q <= no_new_data_timeout_enable_cond;
		end
	end
endmodule // csr_chan

// ===== csr_top.v
// multi-channel service request enables, summary, vector and request pin
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`include "csr_map.vh"
module csr_top #(
	parameter NUM_CH = 4
) (
	input wire i_ref_clk,
	input wire i_arst_n,
	input wire [7:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output wire [7:0] o_rdata,
	input wire [NUM_CH-1:0] i_modem_change,
	input wire [NUM_CH-1:0] i_rx_has_chars,
	input wire [NUM_CH-1:0] i_rx_thresh_hit,
	input wire [NUM_CH-1:0] i_rx_timeout_hit,
	input wire [NUM_CH-1:0] i_tx_fifo_empty,
	input wire [NUM_CH-1:0] i_tx_hold_full,
	input wire [NUM_CH-1:0] i_tx_shift_busy,
	input wire [NUM_CH-1:0] i_tx_shift_empty,
	input wire [NUM_CH-1:0] i_rx_fifo_empty,
	input wire [NUM_CH-1:0] i_rx_idle_expired,
	output wire o_request_out_n,
	output wire o_irq
);
	reg [1:0] chan_sel_q;
	reg [3:0] irq_stat_q;
	reg [3:0] irq_stat_d;
	reg [3:0] irq_mask_q;
	reg [7:0] rdata_q;
	reg [7:0] rdata_d;
	reg req_n_q;
	reg irq_q;
	reg [3:0] type_any;
	reg [3:0] evt_any;
	reg [7:0] sel_en;
	reg [3:0] sel_pend;
	reg [2:0] sel_type;
	reg [7:0] summary;
	integer k;
	integer j;

	wire [8*NUM_CH-1:0] en_flat;
	wire [4*NUM_CH-1:0] pend_flat;
	wire [4*NUM_CH-1:0] evt_flat;
	wire wr_en;
	wire wr_ack;
	wire wr_chan;
	wire wr_stat;
	wire wr_mask;
	wire any_pend;

	assign wr_en = i_wr & (i_addr == `CSR_OFF_ENABLES);
	assign wr_ack = i_wr & (i_addr == `CSR_OFF_ACK);
	assign wr_chan = i_wr & (i_addr == `CSR_OFF_CHAN_SEL);
	assign wr_stat = i_wr & (i_addr == `CSR_OFF_IRQ_STAT);
	assign wr_mask = i_wr & (i_addr == `CSR_OFF_IRQ_MASK);

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g = g + 1)
		begin : g_ch
			csr_chan u_chan (
				.i_ref_clk(i_ref_clk),
				.i_arst_n(i_arst_n),
				.i_en_we(wr_en & (chan_sel_q == g)),
				.i_en_wdata(i_wdata),
				.i_ack((wr_ack & (chan_sel_q == g)) ? i_wdata[3:0] : 4'h0),
				.i_modem_change(i_modem_change[g]),
				.i_rx_has_chars(i_rx_has_chars[g]),
				.i_rx_thresh_hit(i_rx_thresh_hit[g]),
				.i_rx_timeout_hit(i_rx_timeout_hit[g]),
				.i_tx_fifo_empty(i_tx_fifo_empty[g]),
				.i_tx_hold_full(i_tx_hold_full[g]),
				.i_tx_shift_busy(i_tx_shift_busy[g]),
				.i_tx_shift_empty(i_tx_shift_empty[g]),
				.i_rx_fifo_empty(i_rx_fifo_empty[g]),
				.i_rx_idle_expired(i_rx_idle_expired[g]),
				.o_enables(en_flat[8*g +: 8]),
				.o_pend(pend_flat[4*g +: 4]),
				.o_evt(evt_flat[4*g +: 4])
			);
		end
	endgenerate

	// per-type or across all channels
	always @*
	begin
		type_any = 4'h0;
		evt_any = 4'h0;
		for (k = 0; k < NUM_CH; k = k + 1)
		begin
			type_any = type_any | pend_flat[4*k +: 4];
			evt_any = evt_any | evt_flat[4*k +: 4];
		end
	end

	assign any_pend = |type_any;

	// selected channel view
	always @*
	begin
		sel_en = 8'h00;
		sel_pend = 4'h0;
		for (j = 0; j < NUM_CH; j = j + 1)
		begin
			if (chan_sel_q == j)
			begin
				sel_en = en_flat[8*j +: 8];
				sel_pend = pend_flat[4*j +: 4];
			end
		end
	end

	// vector type: exception first, then rx, tx, modem
	always @*
	begin
		if (sel_pend[`CSR_PEND_EXC])
		begin
			sel_type = `CSR_IT_RX_EXC;
		end
		else if (sel_pend[`CSR_PEND_RX])
		begin
			sel_type = `CSR_IT_RX;
		end
		else if (sel_pend[`CSR_PEND_TX])
		begin
			sel_type = `CSR_IT_TX;
		end
		else if (sel_pend[`CSR_PEND_MDM])
		begin
			sel_type = `CSR_IT_MODEM;
		end
		else
		begin
			sel_type = `CSR_IT_NONE;
		end
	end

	always @*
	begin
		summary = {4'h0, type_any};
	end

	// sticky event status, set wins over write-one-to-clear
	always @*
	begin
		irq_stat_d = irq_stat_q;
		if (wr_stat)
		begin
			irq_stat_d = irq_stat_d & ~i_wdata[3:0];
		end
		irq_stat_d = irq_stat_d | evt_any;
	end

	// read mux, data valid the cycle after the strobe
	always @*
	begin
		rdata_d = 8'h00;
		if (i_rd)
		begin
			case (i_addr)
				`CSR_OFF_ENABLES:
				begin
					rdata_d = sel_en & `CSR_EN_WMASK;
				end
				`CSR_OFF_CHAN_SEL:
				begin
					rdata_d = {6'h00, chan_sel_q};
				end
				`CSR_OFF_SUMMARY:
				begin
					rdata_d = summary;
				end
				`CSR_OFF_RX_STATUS:
				begin
					// timeout request carries no character
					rdata_d = 8'h00;
					rdata_d[`CSR_RDS_TIMEOUT] = sel_pend[`CSR_PEND_EXC];
				end
				`CSR_OFF_VECTOR:
				begin
					rdata_d = {1'b0, chan_sel_q, 2'h0, sel_type};
				end
				`CSR_OFF_IRQ_STAT:
				begin
					rdata_d = {4'h0, irq_stat_q};
				end
				`CSR_OFF_IRQ_MASK:
				begin
					rdata_d = {4'h0, irq_mask_q};
				end
				`CSR_OFF_PENDING:
				begin
					rdata_d = {4'h0, sel_pend};
				end
				default:
				begin
					rdata_d = 8'h00;
				end
			endcase
		end
	end

	always @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			chan_sel_q <= `CSR_CHAN_RESET;
			irq_stat_q <= `CSR_IRQ_RESET;
			irq_mask_q <= `CSR_IRQ_RESET;
			rdata_q <= 8'h00;
			req_n_q <= 1'b1;
			irq_q <= 1'b0;
		end
		else
		begin
			if (wr_chan)
			begin
				chan_sel_q <= i_wdata[1:0];
			end
			if (wr_mask)
			begin
				irq_mask_q <= i_wdata[3:0];
			end
			irq_stat_q <= irq_stat_d;
			rdata_q <= rdata_d;
			req_n_q <= ~any_pend;
			irq_q <= |(irq_stat_d & irq_mask_q);
		end
	end

	assign o_rdata = rdata_q;
	assign o_request_out_n = req_n_q;
	assign o_irq = irq_q;
endmodule // csr_top

// ===== csr_assertions.sv
// port checker for the service request top
`timescale 1ns/100ps
module csr_assertions #(
	parameter NUM_CH = 4
) (
	input wire i_ref_clk,
	input wire i_arst_n,
	input wire [7:0] i_addr,
	input wire i_wr,
	input wire i_rd,
	input wire [7:0] o_rdata,
	input wire [NUM_CH-1:0] i_modem_change,
	input wire [NUM_CH-1:0] i_rx_has_chars,
	input wire [NUM_CH-1:0] i_rx_thresh_hit,
	input wire [NUM_CH-1:0] i_rx_timeout_hit,
	input wire [NUM_CH-1:0] i_tx_fifo_empty,
	input wire [NUM_CH-1:0] i_tx_shift_empty,
	input wire [NUM_CH-1:0] i_rx_fifo_empty,
	input wire [NUM_CH-1:0] i_rx_idle_expired,
	input wire o_request_out_n,
	input wire o_irq
);
	wire cause = |(i_modem_change | i_rx_has_chars & (i_rx_thresh_hit | i_rx_timeout_hit)
		| i_tx_fifo_empty | i_tx_shift_empty | i_rx_fifo_empty & i_rx_idle_expired);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside read slot");
	a_unused_bits: assert property ($past(i_rd && i_addr == 8'h06) |-> (o_rdata & 8'h68) == 8'h00)
		else $error("unused enable bits read back set");
	a_pin_cause: assert property ($fell(o_request_out_n) |-> $past(cause, 2))
		else $error("request pin fell without a condition");
	a_pin_release: assert property ($rose(o_request_out_n) |-> $past(i_wr && i_addr == 8'h46, 2))
		else $error("request pin released without service");
	a_irq_cause: assert property ($rose(o_irq) |-> $past(cause) || $past(i_wr && i_addr == 8'h45, 2))
		else $error("irq rose without cause");
	a_vec_shape: assert property ($past(i_rd && i_addr == 8'h43) |-> o_rdata[7] == 1'b0 && o_rdata[4:3] == 2'h0)
		else $error("vector layout wrong");
	a_pend_width: assert property ($past(i_rd && i_addr == 8'h47) |-> o_rdata[7:4] == 4'h0)
		else $error("pending read has extra bits");
	a_unmapped: assert property ($past(i_rd && i_addr == 8'h10) |-> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	c_pin_fall: cover property ($fell(o_request_out_n));
	c_pin_rise: cover property ($rose(o_request_out_n));
	c_irq_rise: cover property ($rose(o_irq));
endmodule // csr_assertions
bind csr_top csr_assertions #(.NUM_CH(NUM_CH)) chk_u (.i_ref_clk, .i_arst_n, .i_addr, .i_wr,
	.i_rd, .o_rdata, .i_modem_change, .i_rx_has_chars, .i_rx_thresh_hit, .i_rx_timeout_hit,
	.i_tx_fifo_empty, .i_tx_shift_empty, .i_rx_fifo_empty, .i_rx_idle_expired,
	.o_request_out_n, .o_irq);

// ===== csr_host.sv
// host processor model: register bus master
`timescale 1ns/100ps
module csr_host (
	input wire i_ref_clk,
	input wire [7:0] i_rdata,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	initial
	begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task hw(input [7:0] a, input [7:0] d);
		@(posedge i_ref_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_ref_clk);
		o_wr <= 1'b0;
	endtask
	// data stands only in the cycle after the read edge
	task hr(input [7:0] a, output [7:0] d);
		@(posedge i_ref_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_ref_clk);
		o_rd <= 1'b0;
		#1 d = i_rdata;
	endtask
endmodule // csr_host

// ===== tb_csr_top.sv
// self-checking bench for the service request top
`timescale 1ns/100ps
module tb_csr_top;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] c [10] = '{default: 4'h0};
	wire [7:0] addr, wdata, rdata;
	wire wr, rd, req_n, irq;
	int n_errors = 0;
	int checks_done = 0;
	logic [9:0] cm [6] = '{10'h001, 10'h006, 10'h00A, 10'h070, 10'h080, 10'h300};
	logic [7:0] en [6] = '{8'h80, 8'h10, 8'h10, 8'h04, 8'h02, 8'h01};
	logic [7:0] pb [6] = '{8'h04, 8'h01, 8'h01, 8'h02, 8'h02, 8'h08};
	logic [7:0] ty [6] = '{8'h01, 8'h03, 8'h03, 8'h02, 8'h02, 8'h07};
	always #10 clk = ~clk;
	csr_host host_u (.i_ref_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd));
	csr_top dut_u (.i_ref_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_modem_change(c[0]), .i_rx_has_chars(c[1]),
		.i_rx_thresh_hit(c[2]), .i_rx_timeout_hit(c[3]), .i_tx_fifo_empty(c[4]),
		.i_tx_hold_full(c[5]), .i_tx_shift_busy(c[6]), .i_tx_shift_empty(c[7]),
		.i_rx_fifo_empty(c[8]), .i_rx_idle_expired(c[9]), .o_request_out_n(req_n), .o_irq(irq));
	task chk(input [7:0] seen, input [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task results;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task wclk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// raise the chosen conditions on the given channels for one cycle
	task pulse(input [9:0] m, input [3:0] ch);
		@(posedge clk);
		for (int j = 0; j < 10; j++) c[j] <= m[j] ? ch : 4'h0;
		@(posedge clk);
		for (int j = 0; j < 10; j++) c[j] <= 4'h0;
	endtask
	task t_regs;
		logic [7:0] d;
		host_u.hr(8'h06, d);
		chk(d, 8'h00);
		host_u.hw(8'h06, 8'hFF);
		host_u.hr(8'h06, d);
		chk(d, 8'h97);
		host_u.hr(8'h10, d);
		chk(d, 8'h00);
		host_u.hw(8'h45, 8'hFF);
		host_u.hr(8'h45, d);
		chk(d, 8'h0F);
	endtask
	task t_type(input int k);
		logic [7:0] d;
		host_u.hw(8'h06, 8'h97 & ~en[k]);
		pulse(cm[k], 4'h1);
		wclk(3);
		chk(req_n, 1'b1);
		host_u.hw(8'h06, en[k]);
		pulse(cm[k], 4'h1);
		wclk(2);
		chk(req_n, 1'b0);
		chk(irq, 1'b1);
		host_u.hr(8'h47, d);
		chk(d, pb[k]);
		host_u.hr(8'h41, d);
		chk(d, pb[k]);
		host_u.hr(8'h43, d);
		chk(d, ty[k]);
		host_u.hr(8'h42, d);
		chk(d, {k == 5, 7'h00});
		host_u.hw(8'h46, 8'h0F);
		host_u.hw(8'h44, 8'hFF);
		wclk(2);
		chk(req_n, 1'b1);
		chk(irq, 1'b0);
	endtask
	// modem change on channels 0 and 1, enabled on channel 1 only, then fifo-empty without queued characters
	task t_chan;
		logic [7:0] d;
		host_u.hw(8'h45, 8'h00);
		host_u.hw(8'h40, 8'h01);
		host_u.hw(8'h06, 8'h80);
		pulse(10'h001, 4'h3);
		wclk(2);
		chk(req_n, 1'b0);
		chk(irq, 1'b0);
		host_u.hr(8'h40, d);
		chk(d, 8'h01);
		host_u.hr(8'h41, d);
		chk(d, 8'h04);
		host_u.hr(8'h43, d);
		chk(d, 8'h21);
		host_u.hr(8'h44, d);
		chk(d, 8'h04);
		host_u.hr(8'h45, d);
		chk(d, 8'h00);
		host_u.hw(8'h46, 8'h0F);
		wclk(2);
		chk(req_n, 1'b1);
		host_u.hw(8'h06, 8'h04);
		pulse(10'h010, 4'h2);
		wclk(3);
		chk(req_n, 1'b1);
		host_u.hr(8'h47, d);
		chk(d, 8'h00);
	endtask
	initial
	begin
		#100000;
		n_errors++;
		results();
	end
	initial
	begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		t_regs();
		t_type(0);
		t_type(1);
		t_type(2);
		t_type(3);
		t_type(4);
		t_type(5);
		t_chan();
		results();
	end
endmodule // tb_csr_top
